// File: rtl/adcpt_consts.vh
// adcpt_consts.vh - offsets, field positions, reset values and trigger codes of the pair trigger block
`ifndef ADCPT_CONSTS_VH
`define ADCPT_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADCPT_ADR_W       5
`define ADCPT_OFF_CTRL    5'h00
`define ADCPT_OFF_STAT    5'h04
`define ADCPT_OFF_CLR     5'h08
`define ADCPT_OFF_IEN     5'h0c
`define ADCPT_OFF_GSW     5'h10
`define ADCPT_OFF_ARB     5'h14

// ****************************************************************
// conversion pair control fields (per pair byte)
// ****************************************************************
`define ADCPT_SRC_LSB     0
`define ADCPT_SRC_W       5
`define ADCPT_SWTRG_BIT   5
`define ADCPT_PAIR_PENDING_FLAG_BIT    6
`define ADCPT_IRQEN_BIT   7
`define ADCPT_CTRL_RST    16'h0000
`define ADCPT_SRC_RST     5'h00

// ****************************************************************
// event status, clear and enable layout
// ****************************************************************
`define ADCPT_EV_DONE     0
`define ADCPT_EV_OVR      2
`define ADCPT_EV_W        4
`define ADCPT_EV_RST      4'h0

// ****************************************************************
// trigger source codes
// ****************************************************************
`define ADCPT_SRC_OFF     5'h00
`define ADCPT_SRC_SW      5'h01
`define ADCPT_SRC_GSW     5'h02
`define ADCPT_SRC_SPEC    5'h03
`define ADCPT_SRC_PRIM    5'h04
`define ADCPT_SRC_TMR     5'h0c
`define ADCPT_SRC_CL      5'h0e
`define ADCPT_SRC_FLT     5'h16

// ****************************************************************
// positions in the hardware trigger edge vector
// ****************************************************************
`define ADCPT_HW_SPEC     0
`define ADCPT_HW_PRIM     1
`define ADCPT_HW_TMR      5
`define ADCPT_HW_CL       7
`define ADCPT_HW_FLT      11
`define ADCPT_HW_W        15

`endif

// File: rtl/adcpt_pair.v
// adcpt_pair.v - trigger source selection and pending flag of one conversion pair
`timescale 1ns/1ps
`default_nettype none
`include "adcpt_consts.vh"

module adcpt_pair (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      sys_rst,
    // selection and trigger events
    input  wire [`ADCPT_SRC_W-1:0]   trigSrc,
    input  wire                      swTrig,
    input  wire                      gswPulse,
    input  wire [`ADCPT_HW_W-1:0]    hwRise,
    // completion and flag
    input  wire                      pendClr,
    output reg                       pair_pending_flag_q,
    output wire                      pendSet,
    output wire                      overrun
);

    // ****************************************************************
    // source decode
    // ****************************************************************
    function srcHit;
        input [4:0]  src;
        input        sw;
        input        gsw;
        input [14:0] hw;
        reg   [4:0]  off;
        begin
            srcHit = 1'b0;
            off    = 5'h00;
            if (src == `ADCPT_SRC_SW) begin
                srcHit = sw;
            end else if (src == `ADCPT_SRC_GSW) begin
                srcHit = gsw;
            end else if (src == `ADCPT_SRC_SPEC) begin
                srcHit = hw[`ADCPT_HW_SPEC];
            end else if (src >= `ADCPT_SRC_PRIM && src <= `ADCPT_SRC_PRIM + 5'h03) begin
                off    = src - `ADCPT_SRC_PRIM;
                srcHit = hw[`ADCPT_HW_PRIM + off[1:0]];
            end else if (src >= `ADCPT_SRC_TMR && src <= `ADCPT_SRC_TMR + 5'h01) begin
                off    = src - `ADCPT_SRC_TMR;
                srcHit = hw[`ADCPT_HW_TMR + off[0]];
            end else if (src >= `ADCPT_SRC_CL && src <= `ADCPT_SRC_CL + 5'h03) begin
                off    = src - `ADCPT_SRC_CL;
                srcHit = hw[`ADCPT_HW_CL + off[1:0]];
            end else if (src >= `ADCPT_SRC_FLT && src <= `ADCPT_SRC_FLT + 5'h03) begin
                off    = src - `ADCPT_SRC_FLT;
                srcHit = hw[`ADCPT_HW_FLT + off[1:0]];
            end
        end
    endfunction

    wire hit;

    // code zero and unlisted codes never hit, so the pair stays idle
    assign hit     = srcHit(trigSrc, swTrig, gswPulse, hwRise);
    assign pendSet = hit & (~pair_pending_flag_q | pendClr);
    assign overrun = hit & pair_pending_flag_q & ~pendClr & ~(trigSrc == `ADCPT_SRC_SW);

    // pending flag: a new trigger beats the completion clear
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pair_pending_flag_q <= 1'b0;
        end else if (hit) begin
            pair_pending_flag_q <= 1'b1;
        end else if (pendClr) begin
            pair_pending_flag_q <= 1'b0;
        end
    end

endmodule // adcpt_pair
`default_nettype wire

// File: rtl/adcpt_top.v
// adcpt_top.v - trigger, pending and interrupt control for two conversion pairs behind wishbone
//
// Overview of operation
// - pair 0 interrupt enable lets a finished pair 0 conversion raise the interrupt
// - pair 0 pending flag sets when its selected trigger asserts
// - pair 0 pending flag reads one until conversion completes, then clears
// - writing one to pair 0 software trigger requests a conversion if selected
// - writing one to pair 1 software trigger requests a conversion if selected
// - a request made while the converter is busy waits until it is free
// - a pair's software trigger bit clears when its pending flag sets
// - source 0 disables, 1 own software, 2 global software, 3 special event
// - sources 4 to 7 pick generator triggers, 12 and 13 timer periods
// - sources 14 to 17 current limit, 22 to 25 generator fault triggers
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcpt_consts.vh"

module adcpt_top #(
    parameter PAIRS = 2
) (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      sys_rst,
    // wishbone slave
    input  wire [`ADCPT_ADR_W-1:0]   wb_adr_i,
    input  wire [31:0]               wb_dat_i,
    input  wire [3:0]                wb_sel_i,
    input  wire                      wb_we_i,
    input  wire                      wb_cyc_i,
    input  wire                      wb_stb_i,
    output reg  [31:0]               wb_dat_o,
    output reg                       wb_ack_o,
    // hardware trigger sources
    input  wire                      pwmSpecialTrig,
    input  wire [3:0]                pwmPrimaryTrig,
    input  wire [1:0]                timerPeriodTrig,
    input  wire [3:0]                pwmCurLimitTrig,
    input  wire [3:0]                pwmFaultTrig,
    // shared converter
    input  wire                      convBusy,
    input  wire                      convDone,
    output reg                       convStart_q,
    output reg                       convPair_q,
    // interrupt
    output reg                       irq_q
);

    // ****************************************************************
    // arbiter states
    // ****************************************************************
    localparam ARB_IDLE = 1'b0;
    localparam ARB_WAIT = 1'b1;

    // ****************************************************************
    // address decode
    // ****************************************************************
    function isReg;
        input [`ADCPT_ADR_W-1:0] adr;
        input [`ADCPT_ADR_W-1:0] off;
        begin
            isReg = (adr == off);
        end
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [PAIRS*`ADCPT_SRC_W-1:0] src_q;
    reg  [PAIRS-1:0]              swTrig_q;
    reg  [PAIRS-1:0]              irqEn_q;
    reg  [PAIRS-1:0]              ovrEn_q;
    reg  [`ADCPT_EV_W-1:0]        stat_q;
    reg                           gsw_q;
    reg  [`ADCPT_HW_W-1:0]        hwPrev_q;
    reg                           arbState_q;
    reg                           lastPair_q;
    reg  [31:0]                   readData;
    reg                           pick;
    reg                           pickValid;
    wire [`ADCPT_HW_W-1:0]        hwNow;
    wire [`ADCPT_HW_W-1:0]        hwRise;
    wire [PAIRS-1:0]              pair_pending_flag;
    wire [PAIRS-1:0]              pendSet;
    wire [PAIRS-1:0]              overrun;
    wire [PAIRS-1:0]              doneEv;
    wire [`ADCPT_EV_W-1:0]        statSet;
    wire [`ADCPT_EV_W-1:0]        statClr;
    wire [`ADCPT_EV_W-1:0]        evEn;
    wire                          busReq;
    wire                          busWr;
    wire [15:0]                   ctrlView;

    // ****************************************************************
    // wishbone handshake
    // ****************************************************************

    // a request is answered one edge after it is seen, then ack drops
    assign busReq = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master samples ack high
    assign busWr  = busReq & wb_we_i & wb_ack_o;

    // ack pulse and read data capture
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= readData;
            end
        end
    end

    // ****************************************************************
    // read multiplexer
    // ****************************************************************

    // per pair control byte: irq enable, pending, software trigger, source
    genvar g;
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : gView
            assign ctrlView[g*8 +: 8] = {irqEn_q[g], pair_pending_flag[g], swTrig_q[g],
                                         src_q[g*`ADCPT_SRC_W +: `ADCPT_SRC_W]};
        end
    endgenerate

    // event enable layout mirrors the status register
    assign evEn = {ovrEn_q, irqEn_q};

    // unmapped and write-only offsets read as zero
    always @* begin
        readData = 32'h0000_0000;
        if (isReg(wb_adr_i, `ADCPT_OFF_CTRL)) begin
            readData[15:0] = ctrlView;
        end else if (isReg(wb_adr_i, `ADCPT_OFF_STAT)) begin
            readData[`ADCPT_EV_W-1:0] = stat_q;
        end else if (isReg(wb_adr_i, `ADCPT_OFF_IEN)) begin
            readData[`ADCPT_EV_W-1:0] = evEn;
        end else if (isReg(wb_adr_i, `ADCPT_OFF_ARB)) begin
            readData[2:0] = {convBusy, convPair_q, arbState_q};
        end
    end

    // ****************************************************************
    // control register writes
    // ****************************************************************
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : gCtrl
            wire ctrlWr;
            wire ienWr;

            assign ctrlWr = busWr & wb_sel_i[g] & isReg(wb_adr_i, `ADCPT_OFF_CTRL);
            assign ienWr  = busWr & wb_sel_i[0] & isReg(wb_adr_i, `ADCPT_OFF_IEN);

            // source select and interrupt enable of this pair
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    src_q[g*`ADCPT_SRC_W +: `ADCPT_SRC_W] <= `ADCPT_SRC_RST;
                    irqEn_q[g]                            <= 1'b0;
                    ovrEn_q[g]                            <= 1'b0;
                end else begin
                    if (ctrlWr) begin
                        src_q[g*`ADCPT_SRC_W +: `ADCPT_SRC_W] <=
                            wb_dat_i[g*8+`ADCPT_SRC_LSB +: `ADCPT_SRC_W];
                        irqEn_q[g] <= wb_dat_i[g*8+`ADCPT_IRQEN_BIT];
                    end else if (ienWr) begin
                        irqEn_q[g] <= wb_dat_i[`ADCPT_EV_DONE+g];
                    end
                    if (ienWr) begin
                        ovrEn_q[g] <= wb_dat_i[`ADCPT_EV_OVR+g];
                    end
                end
            end

            // software trigger: a fresh write of one beats the auto clear
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    swTrig_q[g] <= 1'b0;
                end else if (ctrlWr & wb_dat_i[g*8+`ADCPT_SWTRG_BIT]) begin
                    swTrig_q[g] <= 1'b1;
                end else if (pendSet[g]) begin
                    swTrig_q[g] <= 1'b0;
                end else if (ctrlWr) begin
                    swTrig_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // global software trigger: one cycle pulse per write of one
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gsw_q <= 1'b0;
        end else begin
            gsw_q <= busWr & wb_sel_i[0] & wb_dat_i[0] & isReg(wb_adr_i, `ADCPT_OFF_GSW);
        end
    end

    // ****************************************************************
    // hardware trigger edges
    // ****************************************************************

    // a trigger held high starts only one conversion
    assign hwNow  = {pwmFaultTrig, pwmCurLimitTrig, timerPeriodTrig,
                     pwmPrimaryTrig, pwmSpecialTrig};
    assign hwRise = hwNow & ~hwPrev_q;

    // previous trigger levels
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hwPrev_q <= {`ADCPT_HW_W{1'b0}};
        end else begin
            hwPrev_q <= hwNow;
        end
    end

    // ****************************************************************
    // conversion pairs
    // ****************************************************************
    generate
        for (g = 0; g < PAIRS; g = g + 1) begin : gPair
            // completion of the conversion that is in flight for this pair
            assign doneEv[g] = (arbState_q == ARB_WAIT) & convDone & (convPair_q == g);

            adcpt_pair uPair (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .trigSrc  (src_q[g*`ADCPT_SRC_W +: `ADCPT_SRC_W]),
                .swTrig   (swTrig_q[g]),
                .gswPulse (gsw_q),
                .hwRise   (hwRise),
                .pendClr  (doneEv[g]),
                .pair_pending_flag_q   (pair_pending_flag[g]),
                .pendSet  (pendSet[g]),
                .overrun  (overrun[g])
            );
        end
    endgenerate

    // ****************************************************************
    // shared converter arbiter
    // ****************************************************************

    // round robin pick among pending pairs, other pair first on a tie
    always @* begin
        pick      = 1'b0;
        pickValid = 1'b0;
        if (pair_pending_flag[0] & pair_pending_flag[1]) begin
            pick      = ~lastPair_q;
            pickValid = 1'b1;
        end else if (pair_pending_flag[1]) begin
            pick      = 1'b1;
            pickValid = 1'b1;
        end else if (pair_pending_flag[0]) begin
            pick      = 1'b0;
            pickValid = 1'b1;
        end
    end

    // one conversion at a time; pending pairs wait while the converter is busy
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arbState_q  <= ARB_IDLE;
            convStart_q <= 1'b0;
            convPair_q  <= 1'b0;
            lastPair_q  <= 1'b0;
        end else begin
            convStart_q <= 1'b0;
            case (arbState_q)
                ARB_IDLE: begin
                    if (pickValid & ~convBusy) begin
                        convStart_q <= 1'b1;
                        convPair_q  <= pick;
                        lastPair_q  <= pick;
                        arbState_q  <= ARB_WAIT;
                    end
                end
                ARB_WAIT: begin
                    if (convDone) begin
                        arbState_q <= ARB_IDLE;
                    end
                end
                default: begin
                    arbState_q <= ARB_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // event status and interrupt
    // ****************************************************************

    // done and overrun events; clear register bits are write one to clear
    assign statSet = {overrun, doneEv};
    assign statClr = (busWr & wb_sel_i[0] & isReg(wb_adr_i, `ADCPT_OFF_CLR)) ?
                     wb_dat_i[`ADCPT_EV_W-1:0] : {`ADCPT_EV_W{1'b0}};

    // sticky status, an event wins over a clear in the same cycle
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= `ADCPT_EV_RST;
        end else begin
            stat_q <= statSet | (stat_q & ~statClr);
        end
    end

    // level interrupt while any enabled status bit is set
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & evEn);
        end
    end

endmodule // adcpt_top
`default_nettype wire

// File: verif/adcpt_props.sv
// adcpt_props.sv - concurrent checks on the ports of the pair trigger block
`timescale 1ns/1ps
`default_nettype none
`include "adcpt_consts.vh"

// ****************************************************************
// checker module
// ****************************************************************
module adcpt_props (
    // clock and reset
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    // wishbone
    input wire logic [`ADCPT_ADR_W-1:0] wb_adr_i,
    input wire logic                    wb_we_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    // converter and interrupt
    input wire logic                    convBusy,
    input wire logic                    convDone,
    input wire logic                    convStart_q,
    input wire logic                    convPair_q,
    input wire logic                    irq_q
);
    logic convOut_q;

    // tracks a started conversion that has not yet reported done
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) convOut_q <= 1'b0;
        else if (convStart_q) convOut_q <= 1'b1;
        else if (convDone) convOut_q <= 1'b0;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_req;  wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_rdAck; wb_ack_o && !wb_we_i; endsequence

    property p_ackOne;    s_req |=> wb_ack_o; endproperty
    property p_ackPulse;  wb_ack_o |=> !wb_ack_o; endproperty
    property p_startIdle; convStart_q |-> !$past(convBusy); endproperty
    property p_oneOut;    convStart_q |-> !convOut_q; endproperty
    property p_startOne;  convStart_q |=> !convStart_q; endproperty
    property p_pairHold;  $changed(convPair_q) |-> convStart_q; endproperty
    property p_irqCause;  $rose(irq_q) |-> $past(convDone, 2) || ($past(wb_ack_o, 2) && $past(wb_we_i, 2)); endproperty
    property p_zeroRead;
        s_rdAck ##0 (wb_adr_i == `ADCPT_OFF_CLR || wb_adr_i == `ADCPT_OFF_GSW || wb_adr_i == 5'h18)
            |-> wb_dat_o == 32'h0;
    endproperty
    property p_statWidth; s_rdAck ##0 (wb_adr_i == `ADCPT_OFF_STAT) |-> wb_dat_o[31:4] == 28'h0; endproperty
    property p_ctrlWidth; s_rdAck ##0 (wb_adr_i == `ADCPT_OFF_CTRL) |-> wb_dat_o[31:16] == 16'h0; endproperty

    a_ackOne:    assert property (p_ackOne) else $error("request not acknowledged next cycle");
    a_ackPulse:  assert property (p_ackPulse) else $error("ack longer than one cycle");
    a_startIdle: assert property (p_startIdle) else $error("start while converter busy");
    a_oneOut:    assert property (p_oneOut) else $error("start before previous done");
    a_startOne:  assert property (p_startOne) else $error("start pulse too long");
    a_pairHold:  assert property (p_pairHold) else $error("pair changed without start");
    a_irqCause:  assert property (p_irqCause) else $error("interrupt rose without cause");
    a_zeroRead:  assert property (p_zeroRead) else $error("write-only or unmapped read not zero");
    a_statWidth: assert property (p_statWidth) else $error("status upper bits not zero");
    a_ctrlWidth: assert property (p_ctrlWidth) else $error("control upper bits not zero");
endmodule // adcpt_props

bind adcpt_top adcpt_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .convBusy(convBusy), .convDone(convDone), .convStart_q(convStart_q), .convPair_q(convPair_q),
    .irq_q(irq_q));
`default_nettype wire

// File: verif/adcpt_conv_model.sv
// adcpt_conv_model.sv - behavioural model of the shared converter
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// converter model
// ****************************************************************
module adcpt_conv_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // control from bench and block
    input  wire logic       convStart_q,
    input  wire logic       holdBusy,
    input  wire logic [7:0] latency,
    // answers
    output wire logic       convBusy,
    output wire logic       convDone
);
    logic [7:0] cnt_q;
    logic       run_q;
    logic       done_q;

    // counts out the conversion time and pulses done once
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (convStart_q) begin
                run_q <= 1'b1;
                cnt_q <= latency;
            end else if (run_q) begin
                if (cnt_q == 8'h00) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end else cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // busy reflects other work only
    assign convBusy = holdBusy;
    assign convDone = done_q;
endmodule // adcpt_conv_model
`default_nettype wire

// File: verif/adcpt_bench.sv
// adcpt_bench.sv - self-checking testbench of the pair trigger block
`timescale 1ns/1ps
`default_nettype none
`include "adcpt_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

// ****************************************************************
// bench top
// ****************************************************************
module adcpt_bench;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, holdBusy = 1'b0;
    logic [14:0] hwVec = 15'h0;
    logic [7:0]  latency = 8'h20;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, convBusy, convDone, convStart_q, convPair_q, irq_q;
    int          n_fail = 0, checks = 0;
    logic [31:0] seed = 32'h72d59b53, eRd, code;
    logic        ePr;
    logic [31:0] rdQ[$];
    logic        stQ[$];

    always #5 core_clk = ~core_clk;

    adcpt_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pwmSpecialTrig(hwVec[0]), .pwmPrimaryTrig(hwVec[4:1]),
        .timerPeriodTrig(hwVec[6:5]), .pwmCurLimitTrig(hwVec[10:7]), .pwmFaultTrig(hwVec[14:11]),
        .convBusy(convBusy), .convDone(convDone), .convStart_q(convStart_q), .convPair_q(convPair_q),
        .irq_q(irq_q));

    adcpt_conv_model u_conv (.core_clk(core_clk), .sys_rst(sys_rst), .convStart_q(convStart_q),
        .holdBusy(holdBusy), .latency(latency), .convBusy(convBusy), .convDone(convDone));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task summarize;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // classic single cycle, held until ack is sampled
    task wbCyc(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic w);
        int i;
        i = 0;
        wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s; wb_we_i <= w; wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) begin
            if (++i > 50) begin n_fail++; summarize(); end
            @(posedge core_clk);
        end
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
        @(posedge core_clk);
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        wbCyc(a, d, s, 1'b1);
    endtask

    task rd(input logic [4:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        wbCyc(a, 32'h0, 4'hf, 1'b0);
    endtask

    task waitDone;
        int i;
        i = 0;
        while (convDone !== 1'b1) begin
            if (++i > 400) begin n_fail++; summarize(); end
            @(posedge core_clk);
        end
        @(posedge core_clk);
    endtask

    task pulse(input int b);
        hwVec[b] <= 1'b1; tick(2); hwVec[b] <= 1'b0; tick(1);
    endtask

    // compares read data and started pairs against the oldest notes
    always @(posedge core_clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && rdQ.size() > 0) begin
            eRd = rdQ.pop_front();
            `CHK(wb_dat_o, eRd)
        end
        if (convStart_q === 1'b1) begin
            if (stQ.size() > 0) begin
                ePr = stQ.pop_front();
                `CHK(convPair_q, ePr)
            end else `CHK(convStart_q, 1'b0)
        end
    end

    // main sequence
    initial begin
        tick(16); sys_rst <= 1'b0; tick(1);
        rd(`ADCPT_OFF_CTRL, 32'h0); rd(`ADCPT_OFF_STAT, 32'h0); rd(`ADCPT_OFF_IEN, 32'h0); rd(5'h18, 32'h0);
        for (int i = 0; i < 15; i++) begin
            code = (i == 0) ? 3 : (i < 5) ? i + 3 : (i < 11) ? i + 7 : i + 11;
            seed = lfsr(seed); latency <= 8'h10 + {4'h0, seed[3:0]};
            wr(`ADCPT_OFF_CTRL, code << (8 * (i % 2)), 4'h3);
            pulse((i + 1 + int'(seed[7:4] % 14)) % 15);
            stQ.push_back(i % 2); pulse(i);
            rd(`ADCPT_OFF_CTRL, (code | 32'h40) << (8 * (i % 2)));
            waitDone; tick(2);
            rd(`ADCPT_OFF_CTRL, code << (8 * (i % 2)));
        end
        `CHK(irq_q, 1'b0)
        rd(`ADCPT_OFF_STAT, 32'h3); wr(`ADCPT_OFF_CLR, 32'h3, 4'h1); rd(`ADCPT_OFF_STAT, 32'h0);
        wr(`ADCPT_OFF_CTRL, 32'h0024, 4'h3); tick(10); wr(`ADCPT_OFF_CTRL, 32'h0, 4'h3);
        wr(`ADCPT_OFF_IEN, 32'h1, 4'h1);
        stQ.push_back(1'b1); wr(`ADCPT_OFF_CTRL, 32'h2100, 4'h2); tick(2);
        rd(`ADCPT_OFF_CTRL, 32'h4180);
        rd(`ADCPT_OFF_ARB, 32'h3);
        waitDone; tick(3); `CHK(irq_q, 1'b0)
        stQ.push_back(1'b0); wr(`ADCPT_OFF_CTRL, 32'h00a1, 4'h1); tick(2);
        rd(`ADCPT_OFF_CTRL, 32'h01c1);
        waitDone; tick(3); `CHK(irq_q, 1'b1)
        rd(`ADCPT_OFF_STAT, 32'h3); wr(`ADCPT_OFF_CLR, 32'h1, 4'h1); tick(2); `CHK(irq_q, 1'b0)
        wr(`ADCPT_OFF_IEN, 32'h3, 4'h1); tick(2); `CHK(irq_q, 1'b1)
        wr(`ADCPT_OFF_CLR, 32'h2, 4'h1); tick(2); `CHK(irq_q, 1'b0)
        rd(`ADCPT_OFF_IEN, 32'h3); wr(`ADCPT_OFF_IEN, 32'h0, 4'h1);
        holdBusy <= 1'b1; stQ.push_back(1'b1); stQ.push_back(1'b0); stQ.push_back(1'b0);
        wr(`ADCPT_OFF_CTRL, 32'h2121, 4'h3); tick(12); holdBusy <= 1'b0; tick(4);
        wr(`ADCPT_OFF_CTRL, 32'h0121, 4'h3); waitDone; waitDone; waitDone; tick(3);
        rd(`ADCPT_OFF_STAT, 32'h3);
        stQ.push_back(1'b0); wr(`ADCPT_OFF_CTRL, 32'h0002, 4'h3); wr(`ADCPT_OFF_GSW, 32'h1, 4'h1);
        wr(`ADCPT_OFF_GSW, 32'h1, 4'h1); waitDone; tick(2); rd(`ADCPT_OFF_CTRL, 32'h0002); tick(2);
        rd(`ADCPT_OFF_STAT, 32'h7);
        `CHK(32'(stQ.size()), 32'h0)
        summarize();
    end
endmodule // adcpt_bench
`default_nettype wire
